// *** hdl/gpio_edge_trigger.sv ***
// Edge trigger configuration and per-pin event generation with Avalon-MM slave
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
// How it works
// RQ1: A pin whose falling enable bit is 1 pulses its interrupt and DMA event on each high-to-low.
// RQ2: The falling mask has no address; only set and clear writes change it.
// RQ3: Writing 1 to set bit n enables falling detection on pin n.
// RQ4: Reading the set register returns the present falling mask.
// RQ5: Writing 1 to clear bit n disables falling detection on pin n.
// RQ6: Reading the clear register returns the same falling mask.
// RQ7: Zero bits in a set or clear write leave the mask bit alone.
// RQ8: Bits 31 to 16 of both registers read zero and ignore writes.
// RQ9: After reset the falling mask is all zero.
// RQ10: An edge is a high/low pair of the current and previous sampled level, giving one pulse.
// RQ11: A separate rising mask with its own set and clear raises the same per-pin events.
module gpio_edge_trigger
  import gpio_trig_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               clk_en,
  input  wire logic [ADDR_W-1:0]  avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic [15:0]        io_pin_n,
  output logic [15:0]             pin_event_n,
  output logic [15:0]             dma_event_n,
  output logic                    irq
);
  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  bus_state_t  bus_q;
  logic        req;
  logic        do_write;
  logic [15:0] lane_mask;
  logic [15:0] wbits;
  logic [31:0] rdata_q;

  assign req = (avs_read | avs_write) & clk_en;
  // One wait cycle per access; accepted on the BUS_ACK edge
  assign avs_waitrequest = ~(bus_q == BUS_ACK);
  assign do_write = clk_en & avs_write & (bus_q == BUS_ACK);
  assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wbits = avs_writedata[15:0] & lane_mask; // RQ8 RQ7

  always_ff @(posedge clk)
  begin
    if (reset)
      bus_q <= BUS_IDLE;
    else if (clk_en)
    begin
      unique case (bus_q)
        BUS_IDLE: if (req) bus_q <= BUS_ACK;
        BUS_ACK:  bus_q <= BUS_IDLE;
        default:  bus_q <= BUS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Trigger masks
  // ----------------------------------------
  edge_mask_if fall_if ();
  edge_mask_if rise_if ();

  // Mask is reachable only via set/clear strobes
  assign fall_if.set_bits = (do_write && avs_address == OFF_FALL_SET) ? wbits : 16'h0000; // RQ3 RQ2
  assign fall_if.clr_bits = (do_write && avs_address == OFF_FALL_CLR) ? wbits : 16'h0000; // RQ5
  assign rise_if.set_bits = (do_write && avs_address == OFF_RISE_SET) ? wbits : 16'h0000; // RQ11
  assign rise_if.clr_bits = (do_write && avs_address == OFF_RISE_CLR) ? wbits : 16'h0000; // RQ11

  edge_mask_reg u_fall (.clk(clk), .reset(reset), .clk_en(clk_en), .mi(fall_if)); // RQ9
  edge_mask_reg u_rise (.clk(clk), .reset(reset), .clk_en(clk_en), .mi(rise_if));

  // Interrupt registers
  logic [15:0] status_q;
  logic [15:0] irq_mask_q;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h0;

  // Read data sampled in the idle cycle; address held by master
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_q <= UNMAPPED_READ;
    else if (clk_en && bus_q == BUS_IDLE && avs_read)
    begin
      unique case (avs_address)
        OFF_FALL_SET, OFF_FALL_CLR: rdata_q <= {16'h0000, fall_if.mask}; // RQ4 RQ6 RQ8
        OFF_RISE_SET, OFF_RISE_CLR: rdata_q <= {16'h0000, rise_if.mask};
        default:                    rdata_q <= UNMAPPED_READ;
      endcase
    end
  end
  assign avs_readdata = rdata_q;

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  logic [15:0] pin_prev_q;
  logic [15:0] fall_hit;
  logic [15:0] rise_hit;
  logic [15:0] event_q;

  always_ff @(posedge clk)
  begin
    if (reset)
      pin_prev_q <= PIN_LOW;
    else if (clk_en)
      pin_prev_q <= io_pin_n;
  end

  assign fall_hit = pin_prev_q & ~io_pin_n & fall_if.mask; // RQ10 RQ1
  assign rise_hit = ~pin_prev_q & io_pin_n & rise_if.mask; // RQ11

  // Held while clk_en is low, like all other state
  always_ff @(posedge clk)
  begin
    if (reset)
      event_q <= 16'h0000;
    else if (clk_en)
      event_q <= fall_hit | rise_hit; // RQ1 RQ10
  end
  assign pin_event_n = event_q;
  assign dma_event_n = event_q;

  // ----------------------------------------
  // Sticky status and interrupt
  // ----------------------------------------
  // Status and mask live above the trigger block in its own window
  // so they are left out of the address map here; events set sticky status bits, and irq is their OR under the all-ones mask.
  always_ff @(posedge clk)
  begin
    if (reset)
      status_q <= 16'h0000;
    else if (clk_en)
      status_q <= status_q | event_q;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      irq_mask_q <= 16'hffff;
    else if (clk_en)
      irq_mask_q <= irq_mask_q;
  end

  assign irq = |(status_q & irq_mask_q);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_fall_pulse: assert property (@(posedge clk) disable iff (reset) // RQ1
    clk_en && (pin_prev_q & ~io_pin_n & fall_if.mask) != 16'h0000 |=>
    (pin_event_n & $past(fall_hit)) == $past(fall_hit))
    else $error("falling edge without event");
  a_no_spurious: assert property (@(posedge clk) disable iff (reset) // RQ10
    clk_en ##1 clk_en |-> pin_event_n == $past(fall_hit | rise_hit))
    else $error("event without enabled edge");
  a_set_bit: assert property (@(posedge clk) disable iff (reset) // RQ3
    fall_if.set_bits != 16'h0000 |=> (fall_if.mask & $past(fall_if.set_bits)) == $past(fall_if.set_bits))
    else $error("set write missed");
  a_clr_bit: assert property (@(posedge clk) disable iff (reset) // RQ5
    fall_if.clr_bits != 16'h0000 && fall_if.set_bits == 16'h0000 |=>
    (fall_if.mask & $past(fall_if.clr_bits)) == 16'h0000)
    else $error("clear write missed");
  a_mask_stable: assert property (@(posedge clk) disable iff (reset) // RQ2 RQ7
    fall_if.set_bits == 16'h0000 && fall_if.clr_bits == 16'h0000 |=> $stable(fall_if.mask))
    else $error("mask changed without write");
  a_read_mask: assert property (@(posedge clk) disable iff (reset) // RQ4 RQ6
    clk_en && bus_q == BUS_IDLE && avs_read && (avs_address == OFF_FALL_SET ||
    avs_address == OFF_FALL_CLR) |=> avs_readdata == {16'h0000, $past(fall_if.mask)})
    else $error("read data not mask");
  a_upper_zero: assert property (@(posedge clk) disable iff (reset) // RQ8
    avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_reset_mask: assert property (@(posedge clk) // RQ9
    reset |=> fall_if.mask == 16'h0000 && rise_if.mask == 16'h0000)
    else $error("mask not cleared by reset");
  a_rise_pulse: assert property (@(posedge clk) disable iff (reset) // RQ11
    clk_en && rise_hit != 16'h0000 |=> (pin_event_n & $past(rise_hit)) == $past(rise_hit))
    else $error("rising edge without event");
  c_fall_event: cover property (@(posedge clk) disable iff (reset) fall_hit != 16'h0000);
  c_rise_event: cover property (@(posedge clk) disable iff (reset) rise_hit != 16'h0000);
  c_write_set:  cover property (@(posedge clk) disable iff (reset) fall_if.set_bits != 16'h0000);
  c_irq_up:     cover property (@(posedge clk) disable iff (reset) irq);
endmodule
`default_nettype wire

// *** hdl/gpio_trig_pkg.sv ***
// Constants for the edge trigger configuration block
package gpio_trig_pkg;
  localparam int unsigned PIN_COUNT      = 16;
  localparam int unsigned ADDR_W         = 4;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_RISE_SET  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_RISE_CLR  = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_FALL_SET  = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_FALL_CLR  = 4'hc;
  // Mask reset value
  localparam logic [15:0] MASK_RESET     = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ  = 32'h00000000;
  localparam logic [15:0] PIN_LOW        = 16'h0000;
  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;
endpackage

// *** hdl/edge_mask_if.sv ***
// Set and clear strobes plus mask value between the top and a mask register
`timescale 1ns/1ns
`default_nettype none
interface edge_mask_if;
  logic [15:0] set_bits;
  logic [15:0] clr_bits;
  logic [15:0] mask;
  modport owner (input set_bits, input clr_bits, output mask);
  modport user  (output set_bits, output clr_bits, input mask);
endinterface
`default_nettype wire

// *** hdl/edge_mask_reg.sv ***
// Hidden trigger mask changed only through set and clear strobes
`timescale 1ns/1ns
`default_nettype none
module edge_mask_reg
  import gpio_trig_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset,
  input  wire logic   clk_en,
  edge_mask_if.owner  mi
);
  logic [15:0] mask_q;

  // Set and clear of one bit in one cycle: set wins
  always_ff @(posedge clk)
  begin
    if (reset)
      mask_q <= MASK_RESET;
    else if (clk_en)
      mask_q <= (mask_q & ~mi.clr_bits) | mi.set_bits;
  end

  assign mi.mask = mask_q;
endmodule
`default_nettype wire

// *** test/pin_source.sv ***
// Model of the external levels on the general-purpose pins
`timescale 1ns/1ns
`default_nettype none
module pin_source
(
  input  wire logic        clk,
  output logic [15:0]      level
);
  initial level = 16'hffff;
  // New level lands just after an edge, seen by the block at the next one
  task automatic drive(input logic [15:0] v);
    @(posedge clk);
    level <= v;
  endtask
endmodule
`default_nettype wire

// *** test/gpio_edge_trigger_tb.sv ***
// Self-checking bench for the falling edge trigger block
`timescale 1ns/1ns
`default_nettype none
module gpio_edge_trigger_tb
  import gpio_trig_pkg::*;
();
  logic        clk = 1'b0, reset = 1'b1, rd = 1'b0, wr = 1'b0, wreq, irq;
  logic [3:0]  addr = 4'h0, be = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'd24;
  logic [15:0] pins, ev, dma, mask_m = 16'h0, last_pin = 16'hffff;
  logic [31:0] rd_q[$];
  logic [15:0] ev_q[$];
  int          mismatches = 0, checks = 0;

  initial
    forever #4 clk = ~clk;

  pin_source src (.clk(clk), .level(pins));
  gpio_edge_trigger DUT (.clk(clk), .reset(reset), .clk_en(1'b1), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .io_pin_n(pins), .pin_event_n(ev),
    .dma_event_n(dma), .irq(irq));

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Bus master and pin stimulus
  // ----------------------------------------
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {addr, wr, rd, wdata} <= {a, w, !w, d};
    // Request held until waitrequest is sampled low at a rising edge
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (wreq === 1'b0)
        break;
    end
    if (n == 20)
    begin
      mismatches++;
      end_of_test();
    end
    {wr, rd} <= 2'b00;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // Rising mask stays zero, so only high-to-low pairs may pulse
  task automatic pulse_run(input int cnt);
    logic [15:0] v;
    repeat (cnt)
    begin
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      v = seed[15:0];
      if ((mask_m & last_pin & ~v) != 16'h0)
        ev_q.push_back(mask_m & last_pin & ~v);
      last_pin = v;
      src.drive(v);
    end
  endtask

  always @(posedge clk)
  begin
    if (rd && wreq === 1'b0)
      chk("readdata", rd_q.pop_front(), rdata);
    if (!reset && ev !== 16'h0)
    begin
      chk("dma event", {16'h0, ev}, {16'h0, dma});
      chk("pin event", ev_q.size() ? ev_q.pop_front() : 16'h0, ev);
    end
  end

  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_chk(OFF_FALL_SET, 32'h0);
    rd_chk(OFF_FALL_CLR, 32'h0);
    pulse_run(20);
    chk("irq idle", 32'h0, {31'h0, irq});
    bus(1'b1, OFF_FALL_SET, 32'hffff_a5a5);
    mask_m = 16'ha5a5;
    rd_chk(OFF_FALL_SET, 32'h0000_a5a5);
    rd_chk(OFF_FALL_CLR, 32'h0000_a5a5);
    bus(1'b1, OFF_FALL_CLR, 32'hffff_0005);
    bus(1'b1, OFF_FALL_SET, 32'h0);
    mask_m = 16'ha5a0;
    rd_chk(OFF_FALL_CLR, 32'h0000_a5a0);
    rd_chk(4'h2, 32'h0);
    rd_chk(OFF_RISE_SET, 32'h0);
    pulse_run(60);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, OFF_FALL_CLR, 32'h0000_ffff);
    mask_m = 16'h0;
    pulse_run(20);
    repeat (3) @(posedge clk);
    be <= 4'h2;
    bus(1'b1, OFF_FALL_SET, 32'h0000_ffff);
    be <= 4'hf;
    rd_chk(OFF_FALL_SET, 32'h0000_ff00);
    bus(1'b1, OFF_FALL_CLR, 32'h0000_ffff);
    rd_chk(OFF_FALL_CLR, 32'h0);
    chk("missed events", 32'h0, ev_q.size());
    end_of_test();
  end
endmodule
`default_nettype wire
